// ---- verilog/fcs_pkg.sv ----
/*
 Shared constants and types of the flash command sequencer controller.
 Assumes a 125 MHz system clock and a word or byte wide parallel flash.
*/
`default_nettype none
package fcs_pkg;
	localparam int CLK_MHZ = 125;
	localparam int T_SETUP_NS = 20;
	localparam int T_WP_NS = 40;
	localparam int T_HOLD_NS = 20;
	localparam int T_GAP_NS = 30;
	localparam int T_ACC_NS = 100;
	localparam int T_SUSP_US = 20;
	localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] WP_CYC = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] GAP_CYC = 8'((T_GAP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] SYNC_CYC = 8'h03;
	localparam logic [7:0] RD_CYC = 8'((T_ACC_NS * CLK_MHZ + 999) / 1000) + SYNC_CYC;
	localparam logic [11:0] SUSP_CYC = 12'(T_SUSP_US * CLK_MHZ);
	localparam logic [19:0] ADDR_U1_WORD = 20'h00555;
	localparam logic [19:0] ADDR_U2_WORD = 20'h002aa;
	localparam logic [19:0] ADDR_U1_BYTE = 20'h00aaa;
	localparam logic [19:0] ADDR_U2_BYTE = 20'h00555;
	localparam logic [19:0] PV_OFF_WORD = 20'h00002;
	localparam logic [19:0] PV_OFF_BYTE = 20'h00004;
	localparam logic [7:0] D_UNLOCK1 = 8'haa;
	localparam logic [7:0] D_UNLOCK2 = 8'h55;
	localparam logic [7:0] D_PROGRAM = 8'ha0;
	localparam logic [7:0] D_BYPASS = 8'h20;
	localparam logic [7:0] D_BYP_EXIT1 = 8'h90;
	localparam logic [7:0] D_BYP_EXIT2 = 8'h00;
	localparam logic [7:0] D_ERASE = 8'h80;
	localparam logic [7:0] D_CHIP = 8'h10;
	localparam logic [7:0] D_SECTOR = 8'h30;
	localparam logic [7:0] D_SUSPEND = 8'hb0;
	localparam logic [7:0] D_RESUME = 8'h30;
	localparam logic [7:0] D_AUTOSEL = 8'h90;
	localparam logic [7:0] D_RESET = 8'hf0;
	localparam int TOGGLE_BIT = 6;
	localparam int TIMEOUT_BIT = 5;
	localparam int AV_AW = 3;
	localparam logic [AV_AW-1:0] REG_CMD = 3'h0;
	localparam logic [AV_AW-1:0] REG_ADDR = 3'h1;
	localparam logic [AV_AW-1:0] REG_WDATA = 3'h2;
	localparam logic [AV_AW-1:0] REG_STATUS = 3'h3;
	localparam logic [AV_AW-1:0] REG_RDATA = 3'h4;
	localparam int CMD_BYTE_BIT = 8;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_BYPASS_BIT = 1;
	localparam int ST_ERASING_BIT = 2;
	localparam int ST_SUSP_BIT = 3;
	localparam int ST_AUTOSEL_BIT = 4;
	localparam int ST_READY_BIT = 5;
	localparam int ST_ERROR_BIT = 6;
	localparam int ST_REFUSED_BIT = 7;
	typedef enum logic [3:0] {OP_READ, OP_RESET, OP_PROGRAM, OP_BYP_ENTER, OP_BYP_PROG,
		OP_BYP_RESET, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME, OP_AUTOSEL,
		OP_PROT_VERIFY, OP_POLL} fcs_op_type;
	typedef enum logic [2:0] {K_WR, K_RD, K_POLL, K_WAIT, K_END} fcs_kind_type;
	typedef struct packed {
		fcs_kind_type kind;
		logic [19:0] addr;
		logic [15:0] data;
	} fcs_step_type;
endpackage
`default_nettype wire

// ---- verilog/fcs_bus_cycle.sv ----
/*
 One asynchronous flash bus cycle, write or read, timed in system clocks.
 Assumes the start pulse comes from logic on the same clock and that
 the data bus returns from the flash pins without a clock.
*/
`timescale 1ns/1ns
`default_nettype none
module fcs_bus_cycle (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic is_read,
	input wire logic [19:0] addr,
	input wire logic [15:0] wdata,
	output logic done,
	output logic [15:0] rdata,
	output logic [19:0] fl_addr,
	output logic [15:0] fl_dq_out,
	output logic fl_dq_oe,
	input wire logic [15:0] fl_dq_in,
	output logic fl_ce_n,
	output logic fl_we_n,
	output logic fl_oe_n
);
	import fcs_pkg::*;
	typedef enum logic [2:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD, BC_GAP} fcs_bc_type;
	fcs_bc_type ph_q;
	logic [7:0] cnt_q;
	logic rd_q;
	logic [15:0] dq_s1_q;
	logic [15:0] dq_s2_q;
	logic [15:0] dq_s3_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
			dq_s3_q <= 16'h0000;
		end else begin
			dq_s1_q <= fl_dq_in;
			dq_s2_q <= dq_s1_q;
			dq_s3_q <= dq_s2_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q <= BC_IDLE;
			cnt_q <= 8'h00;
			rd_q <= 1'b0;
			done <= 1'b0;
			rdata <= 16'h0000;
			fl_addr <= 20'h00000;
			fl_dq_out <= 16'h0000;
			fl_dq_oe <= 1'b0;
			fl_ce_n <= 1'b1;
			fl_we_n <= 1'b1;
			fl_oe_n <= 1'b1;
		end else begin
			done <= 1'b0;
			unique case (ph_q)
				BC_IDLE: begin
					if (start) begin
						// Address and data settle before either strobe falls
						fl_addr <= addr;
						fl_dq_out <= is_read ? 16'h0000 : wdata;
						fl_dq_oe <= !is_read;
						rd_q <= is_read;
						fl_ce_n <= 1'b0;
						cnt_q <= SETUP_CYC;
						ph_q <= BC_SETUP;
					end
				end
				BC_SETUP: begin
					if (cnt_q == 8'h01) begin
						fl_oe_n <= !rd_q;
						fl_we_n <= rd_q;
						cnt_q <= rd_q ? RD_CYC : WP_CYC;
						ph_q <= BC_STROBE;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				BC_STROBE: begin
					if (cnt_q != 8'h01) begin
						cnt_q <= cnt_q - 8'h01;
					end else if (!rd_q) begin
						// Write strobe rises first with data still held
						fl_we_n <= 1'b1;
						cnt_q <= HOLD_CYC;
						ph_q <= BC_HOLD;
					end else if (dq_s2_q == dq_s3_q) begin
						// Status bits may still move, so wait for two equal samples
						rdata <= dq_s3_q;
						fl_oe_n <= 1'b1;
						fl_ce_n <= 1'b1;
						cnt_q <= GAP_CYC;
						ph_q <= BC_GAP;
					end
				end
				BC_HOLD: begin
					if (cnt_q == 8'h01) begin
						fl_ce_n <= 1'b1;
						fl_dq_oe <= 1'b0;
						cnt_q <= GAP_CYC;
						ph_q <= BC_GAP;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				BC_GAP: begin
					if (cnt_q == 8'h01) begin
						done <= 1'b1;
						ph_q <= BC_IDLE;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				default: ph_q <= BC_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- verilog/fcs_ctrl.sv ----
/*
 Host-side controller that issues unlock-prefixed command sequences to a
 parallel boot-sector flash and reports the flash mode to software.
 Assumes an Avalon-MM master on the system clock and a flash whose pins
 are wired straight to the FL_ ports, with the ready/busy line pulled up.
*/
// Chosen here: the Avalon-MM slave port and the register addresses.
//
// Function
// - Unlock addresses 555/2AA word, AAA/555 byte
// - Program is AA, 55, A0, then data
// - Bypass entered by AA, 55, 20 first
// - Bypass program is A0 then data
// - Bypass exit is 90 then 00
// - Erase is AA,55,80,AA,55 then 10/30
// - Suspend is one B0 write
// - Reset command leaves autoselect or timeout
// - Autoselect is AA, 55, 90, then read
// - All sequence cycles are writes except reads
`timescale 1ns/1ns
`default_nettype none
module fcs_ctrl (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic [fcs_pkg::AV_AW-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic [19:0] FL_ADDR,
	output logic [15:0] FL_DQ_OUT,
	output logic FL_DQ_OE,
	input wire logic [15:0] FL_DQ_IN,
	output logic FL_CE_N,
	output logic FL_WE_N,
	output logic FL_OE_N,
	output logic FL_BYTE_N,
	input wire logic FL_READY_BUSY
);
	import fcs_pkg::*;
	typedef enum logic [1:0] {ST_IDLE, ST_STEP, ST_BUS, ST_WAIT} fcs_state_type;

	fcs_state_type state_q;
	fcs_op_type op_q;
	fcs_step_type cur;
	logic [2:0] idx_q;
	logic byte_mode_q;
	logic [19:0] tgt_addr_q;
	logic [15:0] wdata_q;
	logic [15:0] rdata_q;
	logic bypass_q;
	logic erasing_q;
	logic sector_erase_q;
	logic suspended_q;
	logic autosel_q;
	logic error_q;
	logic refused_q;
	logic poll_n_q;
	logic tmo_seen_q;
	logic [15:0] poll_prev_q;
	logic [11:0] wait_q;
	logic bc_start_q;
	logic bc_done;
	logic [15:0] bc_rdata;
	logic rb_s1_q;
	logic rb_s2_q;
	logic rb_s3_q;
	logic ready_q;
	logic [31:0] reg_rd;
	logic busy;
	logic acc_wr;
	logic cmd_acc;
	logic cmd_ok;
	logic toggled;
	logic poll_fail;
	logic at_end;
	logic clr_wr;

	// Sequence table: one bus step per index
	function automatic fcs_step_type seq_step(fcs_op_type op, logic [2:0] idx, logic bm,
			logic [19:0] ta, logic [15:0] wd);
		fcs_step_type s;
		logic [19:0] u1;
		logic [19:0] u2;
		logic [19:0] sa;
		logic [7:0] c3;
		s = '{K_END, 20'h00000, 16'h0000};
		u1 = bm ? ADDR_U1_BYTE : ADDR_U1_WORD;
		u2 = bm ? ADDR_U2_BYTE : ADDR_U2_WORD;
		// Only the sector bits survive, upper address bits of commands stay zero
		sa = bm ? {ta[19:13], 13'h0000} : {1'b0, ta[18:12], 12'h000};
		unique case (op)
			OP_PROGRAM: c3 = D_PROGRAM;
			OP_BYP_ENTER: c3 = D_BYPASS;
			OP_CHIP_ERASE, OP_SECTOR_ERASE: c3 = D_ERASE;
			default: c3 = D_AUTOSEL;
		endcase
		unique case (op)
			OP_READ: if (idx == 3'h0) s = '{K_RD, ta, 16'h0000};
			OP_RESET: if (idx == 3'h0) s = '{K_WR, 20'h00000, {8'h00, D_RESET}};
			OP_BYP_PROG: begin
				if (idx == 3'h0) s = '{K_WR, 20'h00000, {8'h00, D_PROGRAM}};
				else if (idx == 3'h1) s = '{K_WR, ta, wd};
				else if (idx == 3'h2) s = '{K_POLL, ta, 16'h0000};
			end
			OP_BYP_RESET: begin
				if (idx == 3'h0) s = '{K_WR, 20'h00000, {8'h00, D_BYP_EXIT1}};
				else if (idx == 3'h1) s = '{K_WR, 20'h00000, {8'h00, D_BYP_EXIT2}};
			end
			OP_SUSPEND: begin
				if (idx == 3'h0) s = '{K_WR, 20'h00000, {8'h00, D_SUSPEND}};
				else if (idx == 3'h1) s = '{K_WAIT, 20'h00000, 16'h0000};
			end
			OP_RESUME: if (idx == 3'h0) s = '{K_WR, 20'h00000, {8'h00, D_RESUME}};
			OP_POLL: if (idx == 3'h0) s = '{K_POLL, ta, 16'h0000};
			default: begin
				// Upper data byte driven zero in every command cycle
				unique case (idx)
					3'h0: s = '{K_WR, u1, {8'h00, D_UNLOCK1}};
					3'h1: s = '{K_WR, u2, {8'h00, D_UNLOCK2}};
					3'h2: s = '{K_WR, u1, {8'h00, c3}};
					3'h3: begin
						if (op == OP_PROGRAM) s = '{K_WR, ta, wd};
						else if (op == OP_AUTOSEL) s = '{K_RD, ta, 16'h0000};
						else if (op == OP_PROT_VERIFY)
							s = '{K_RD, sa | (bm ? PV_OFF_BYTE : PV_OFF_WORD), 16'h0000};
						else if (op != OP_BYP_ENTER) s = '{K_WR, u1, {8'h00, D_UNLOCK1}};
					end
					3'h4: begin
						if (op == OP_PROGRAM) s = '{K_POLL, ta, 16'h0000};
						else if (op == OP_CHIP_ERASE || op == OP_SECTOR_ERASE)
							s = '{K_WR, u2, {8'h00, D_UNLOCK2}};
					end
					3'h5: begin
						if (op == OP_CHIP_ERASE) s = '{K_WR, u1, {8'h00, D_CHIP}};
						else if (op == OP_SECTOR_ERASE) s = '{K_WR, sa, {8'h00, D_SECTOR}};
					end
					default: s = '{K_END, 20'h00000, 16'h0000};
				endcase
			end
		endcase
		return s;
	endfunction

	always_comb begin
		cur = seq_step(op_q, idx_q, byte_mode_q, tgt_addr_q, wdata_q);
	end

	assign busy = state_q != ST_IDLE;
	assign acc_wr = AVS_WRITE && !AVS_WAITREQUEST;
	assign cmd_acc = acc_wr && AVS_ADDRESS == REG_CMD;
	assign clr_wr = acc_wr && AVS_ADDRESS == REG_STATUS;
	assign toggled = bc_rdata[TOGGLE_BIT] ^ poll_prev_q[TOGGLE_BIT];
	assign poll_fail = state_q == ST_BUS && bc_done && cur.kind == K_POLL && poll_n_q &&
		toggled && bc_rdata[TIMEOUT_BIT] && tmo_seen_q;
	assign at_end = state_q == ST_STEP && cur.kind == K_END;

	// Unknown codes and illegal mode changes never reach the pins
	always_comb begin
		unique case (AVS_WRITEDATA[3:0])
			4'(OP_SUSPEND): cmd_ok = erasing_q && sector_erase_q && !suspended_q;
			4'(OP_RESUME): cmd_ok = suspended_q;
			4'(OP_BYP_PROG): cmd_ok = bypass_q;
			default: cmd_ok = AVS_WRITEDATA[3:0] <= 4'(OP_POLL);
		endcase
	end

	always_comb begin
		reg_rd = 32'h00000000;
		unique case (AVS_ADDRESS)
			REG_ADDR: reg_rd[19:0] = tgt_addr_q;
			REG_WDATA: reg_rd[15:0] = wdata_q;
			REG_RDATA: reg_rd[15:0] = rdata_q;
			REG_CMD: reg_rd[3:0] = op_q;
			REG_STATUS: begin
				reg_rd[ST_BUSY_BIT] = busy;
				reg_rd[ST_BYPASS_BIT] = bypass_q;
				reg_rd[ST_ERASING_BIT] = erasing_q;
				reg_rd[ST_SUSP_BIT] = suspended_q;
				reg_rd[ST_AUTOSEL_BIT] = autosel_q;
				reg_rd[ST_READY_BIT] = ready_q;
				reg_rd[ST_ERROR_BIT] = error_q;
				reg_rd[ST_REFUSED_BIT] = refused_q;
			end
			default: reg_rd = 32'h00000000;
		endcase
	end

	// Answer one cycle after the request; order and target writes stall while busy
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= 32'h00000000;
		end else if (!AVS_WAITREQUEST) begin
			AVS_WAITREQUEST <= 1'b1;
		end else if (AVS_READ) begin
			AVS_WAITREQUEST <= 1'b0;
			AVS_READDATA <= reg_rd;
		end else if (AVS_WRITE && !(busy && AVS_ADDRESS < REG_STATUS)) begin
			AVS_WAITREQUEST <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			tgt_addr_q <= 20'h00000;
			wdata_q <= 16'h0000;
		end else if (acc_wr && AVS_ADDRESS == REG_ADDR) begin
			tgt_addr_q <= AVS_WRITEDATA[19:0];
		end else if (acc_wr && AVS_ADDRESS == REG_WDATA) begin
			wdata_q <= AVS_WRITEDATA[15:0];
		end
	end

	// Ready/busy pin, filtered
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			rb_s1_q <= 1'b1;
			rb_s2_q <= 1'b1;
			rb_s3_q <= 1'b1;
			ready_q <= 1'b1;
		end else begin
			rb_s1_q <= FL_READY_BUSY;
			rb_s2_q <= rb_s1_q;
			rb_s3_q <= rb_s2_q;
			if (rb_s2_q == rb_s3_q) ready_q <= rb_s3_q;
		end
	end

	// Sticky error flags: a new event wins over a clear in the same cycle
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			error_q <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			error_q <= poll_fail || (error_q && !(clr_wr && AVS_WRITEDATA[ST_ERROR_BIT]));
			refused_q <= (cmd_acc && !cmd_ok) ||
				(refused_q && !(clr_wr && AVS_WRITEDATA[ST_REFUSED_BIT]));
		end
	end

	// Flash mode as the host has driven it
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			bypass_q <= 1'b0;
			erasing_q <= 1'b0;
			sector_erase_q <= 1'b0;
			suspended_q <= 1'b0;
			autosel_q <= 1'b0;
		end else if (at_end) begin
			unique case (op_q)
				OP_BYP_ENTER: bypass_q <= 1'b1;
				OP_BYP_RESET: bypass_q <= 1'b0;
				OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
					erasing_q <= 1'b1;
					sector_erase_q <= op_q == OP_SECTOR_ERASE;
				end
				OP_SUSPEND: suspended_q <= 1'b1;
				OP_RESUME: suspended_q <= 1'b0;
				OP_AUTOSEL, OP_PROT_VERIFY: autosel_q <= 1'b1;
				OP_RESET: autosel_q <= 1'b0;
				// A settled toggle bit while suspended does not mean the erase is done
				OP_POLL: if (!suspended_q) erasing_q <= 1'b0;
				default: autosel_q <= autosel_q;
			endcase
		end
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_q <= ST_IDLE;
			op_q <= OP_READ;
			idx_q <= 3'h0;
			byte_mode_q <= 1'b0;
			FL_BYTE_N <= 1'b1;
			rdata_q <= 16'h0000;
			poll_n_q <= 1'b0;
			tmo_seen_q <= 1'b0;
			poll_prev_q <= 16'h0000;
			wait_q <= 12'h000;
			bc_start_q <= 1'b0;
		end else begin
			bc_start_q <= 1'b0;
			FL_BYTE_N <= !byte_mode_q;
			unique case (state_q)
				ST_IDLE: begin
					if (cmd_acc && cmd_ok) begin
						op_q <= fcs_op_type'(AVS_WRITEDATA[3:0]);
						byte_mode_q <= AVS_WRITEDATA[CMD_BYTE_BIT];
						idx_q <= 3'h0;
						poll_n_q <= 1'b0;
						tmo_seen_q <= 1'b0;
						state_q <= ST_STEP;
					end
				end
				ST_STEP: begin
					unique case (cur.kind)
						K_WR, K_RD, K_POLL: begin
							bc_start_q <= 1'b1;
							state_q <= ST_BUS;
						end
						K_WAIT: begin
							wait_q <= SUSP_CYC;
							state_q <= ST_WAIT;
						end
						K_END: state_q <= ST_IDLE;
					endcase
				end
				ST_BUS: begin
					if (bc_done) begin
						state_q <= ST_STEP;
						if (cur.kind == K_POLL) begin
							// Two reads in a row decide
							poll_prev_q <= bc_rdata;
							poll_n_q <= 1'b1;
							if (poll_n_q && !toggled) begin
								idx_q <= idx_q + 3'h1;
								poll_n_q <= 1'b0;
							end else if (poll_n_q && bc_rdata[TIMEOUT_BIT]) begin
								tmo_seen_q <= 1'b1;
								if (tmo_seen_q) begin
									// Still toggling after timeout: back to array
									op_q <= OP_RESET;
									idx_q <= 3'h0;
								end
							end
						end else begin
							if (cur.kind == K_RD)
								rdata_q <= op_q == OP_PROT_VERIFY ?
									{8'h00, bc_rdata[7:0]} : bc_rdata;
							idx_q <= idx_q + 3'h1;
						end
					end
				end
				ST_WAIT: begin
					if (wait_q == 12'h001) begin
						idx_q <= idx_q + 3'h1;
						state_q <= ST_STEP;
					end else begin
						wait_q <= wait_q - 12'h001;
					end
				end
			endcase
		end
	end

	fcs_bus_cycle u_cycle (
		.clk(CLOCK),
		.rst_n(RESET_N),
		.start(bc_start_q),
		.is_read(cur.kind != K_WR),
		.addr(cur.addr),
		.wdata(cur.data),
		.done(bc_done),
		.rdata(bc_rdata),
		.fl_addr(FL_ADDR),
		.fl_dq_out(FL_DQ_OUT),
		.fl_dq_oe(FL_DQ_OE),
		.fl_dq_in(FL_DQ_IN),
		.fl_ce_n(FL_CE_N),
		.fl_we_n(FL_WE_N),
		.fl_oe_n(FL_OE_N)
	);
endmodule
`default_nettype wire

// ---- sim/fcs_ctrl_assertions.sv ----
/*
 Concurrent checks on the pins of the flash command sequencer controller.
 Assumes it is bound to fcs_ctrl and sees only that module's ports.
*/
`timescale 1ns/1ns
`default_nettype none
module fcs_ctrl_assertions (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic [fcs_pkg::AV_AW-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic [19:0] FL_ADDR,
	input wire logic [15:0] FL_DQ_OUT,
	input wire logic FL_DQ_OE,
	input wire logic [15:0] FL_DQ_IN,
	input wire logic FL_CE_N,
	input wire logic FL_WE_N,
	input wire logic FL_OE_N,
	input wire logic FL_BYTE_N,
	input wire logic FL_READY_BUSY
);
	import fcs_pkg::*;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	AST_ADDR_HELD: assert property (!FL_CE_N && !$past(FL_CE_N) |-> $stable(FL_ADDR))
		else $error("flash address moved inside a cycle");
	AST_DATA_HELD: assert property (!FL_CE_N && !$past(FL_CE_N) && FL_DQ_OE |-> $stable(FL_DQ_OUT))
		else $error("flash data moved inside a write");
	AST_WE_IN_CE: assert property (!FL_WE_N |-> !FL_CE_N && FL_DQ_OE)
		else $error("write strobe outside chip select");
	AST_WE_SETUP: assert property ($fell(FL_WE_N) |-> !$past(FL_CE_N, 2))
		else $error("write strobe fell without setup");
	AST_WE_WIDTH: assert property ($fell(FL_WE_N) |-> !FL_WE_N [*4])
		else $error("write pulse too short");
	AST_UNLOCK1: assert property ($fell(FL_WE_N) && FL_DQ_OUT == 16'h00aa |->
		FL_ADDR == (FL_BYTE_N ? ADDR_U1_WORD : ADDR_U1_BYTE))
		else $error("first unlock at wrong address");
	AST_UNLOCK2: assert property ($fell(FL_WE_N) && FL_DQ_OUT == 16'h0055 |->
		FL_ADDR == (FL_BYTE_N ? ADDR_U2_WORD : ADDR_U2_BYTE))
		else $error("second unlock at wrong address");
	AST_NO_RD_WR: assert property (!(!FL_WE_N && !FL_OE_N))
		else $error("read and write strobes together");
	AST_NO_CLASH: assert property (FL_DQ_OE |-> FL_OE_N)
		else $error("host drives data during a read");
	AST_UPPER_ZERO: assert property ($fell(FL_WE_N) && FL_DQ_OUT[7:0] inside {8'hb0, 8'hf0, 8'h80}
		|-> FL_DQ_OUT[15:8] == 8'h00)
		else $error("upper byte set in command cycle");
	AST_WAIT_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low for more than one cycle");
	cover property ($fell(FL_WE_N) && FL_DQ_OUT == 16'h00aa);
	cover property ($fell(FL_OE_N));
	cover property (!AVS_WAITREQUEST && AVS_READ);
endmodule
`default_nettype wire

// ---- sim/fcs_flash_model.sv ----
/*
 Behavioural boot-sector flash on the pins of the controller.
 Assumes one device, clean strobes, and a pulled-up ready line.
*/
`timescale 1ns/1ns
`default_nettype none
module fcs_flash_model (
	input wire logic [19:0] fl_addr,
	input wire logic [15:0] fl_dq_out,
	input wire logic fl_ce_n,
	input wire logic fl_we_n,
	input wire logic fl_oe_n,
	input wire logic fl_byte_n,
	output logic [15:0] fl_dq_in,
	output logic fl_ready_busy
);
	import fcs_pkg::*;
	logic [15:0] mem [logic [19:0]];
	logic [19:0] a_q;
	logic [15:0] v;
	logic [15:0] last_q = 16'hffff;
	logic [15:0] tog_q = 16'h0000;
	logic byp_q = 1'b0;
	logic asel_q = 1'b0;
	logic susp_q = 1'b0;
	logic chip_q = 1'b0;
	int step = 0;
	time ers_t = 0;
	time prog_t = 0;
	time rem = 0;
	wire wr_act = !fl_ce_n && !fl_we_n;
	wire rd_act = !fl_ce_n && !fl_oe_n;
	function automatic logic hit(input logic [19:0] a, input logic second);
		// Bits above the unlock field are not compared
		if (fl_byte_n) return a[10:0] == (second ? 11'h2aa : 11'h555);
		return a[11:0] == (second ? 12'h555 : 12'haaa);
	endfunction
	function automatic logic busy();
		return $time < prog_t || (!susp_q && $time < ers_t);
	endfunction
	initial fl_dq_in = 16'hffff;
	always #8 fl_ready_busy = !busy();
	always @(posedge wr_act) a_q = fl_addr;
	always @(negedge wr_act) begin
		logic [7:0] d;
		d = fl_dq_out[7:0];
		if (step == 3 || step == 7) begin
			mem[a_q] = fl_dq_out;
			prog_t = $time + 1500;
			step = 0;
		end else if (step == 8) begin
			byp_q = byp_q && d != 8'h00;
			step = 0;
		end else if (step == 6 && (d == 8'h10 && hit(a_q, 1'b0) || d == 8'h30)) begin
			chip_q = d == 8'h10;
			foreach (mem[k]) if (chip_q || k[18:12] == a_q[18:12]) mem[k] = 16'hffff;
			ers_t = $time + 4000;
			step = 0;
		end else if (d == 8'hb0) begin
			if (!chip_q && !susp_q && $time < ers_t) rem = ers_t - $time;
			susp_q = susp_q || (!chip_q && $time < ers_t);
			step = 0;
		end else if (d == 8'h30 && step == 0) begin
			if (susp_q) ers_t = $time + rem;
			susp_q = 1'b0;
		end else if (d == 8'hf0) begin
			asel_q = 1'b0;
			step = 0;
		end else if (byp_q && step == 0 && d inside {8'ha0, 8'h90}) step = d == 8'ha0 ? 7 : 8;
		else if (step == 0 && d == 8'haa && hit(a_q, 1'b0)) step = 1;
		else if (step == 1 && d == 8'h55 && hit(a_q, 1'b1)) step = 2;
		else if (step == 4 && d == 8'haa && hit(a_q, 1'b0)) step = 5;
		else if (step == 5 && d == 8'h55 && hit(a_q, 1'b1)) step = 6;
		else if (step == 2 && hit(a_q, 1'b0) && d inside {8'ha0, 8'h20, 8'h90, 8'h80}) begin
			byp_q = byp_q || d == 8'h20;
			asel_q = asel_q || d == 8'h90;
			step = d == 8'ha0 ? 3 : (d == 8'h80 ? 4 : 0);
		end else step = 0;
	end
	always @(posedge rd_act) begin
		if (asel_q && fl_addr[7:0] inside {8'h02, 8'h04}) v = {15'h0000, fl_addr[18:12] == 7'h01};
		else if (asel_q) v = 16'h00c5; // Arbitrary identity value
		else if (busy()) begin
			tog_q = tog_q ^ 16'h0044;
			v = tog_q;
		end else v = mem.exists(fl_addr) ? mem[fl_addr] : 16'hffff;
		#60 fl_dq_in = v;
		last_q = v;
	end
	// Released bus shows the inverse so stale data cannot pass
	always @(negedge rd_act) fl_dq_in = ~last_q;
endmodule
`default_nettype wire

// ---- sim/test_flash_command_sequencer.sv ----
/*
 Self-checking bench of the flash command sequencer controller.
 Assumes the behavioural flash model on the pins and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module test_flash_command_sequencer;
	import fcs_pkg::*;
	typedef struct packed {
		logic [31:0] cmd;
		logic [19:0] addr;
		logic [15:0] wd;
		logic [2:0] rg;
		logic [31:0] mask;
		logic [31:0] exp;
	} fcs_row_type;
	logic CLOCK, RESET_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, FL_DQ_OE, FL_CE_N, FL_WE_N;
	logic FL_OE_N, FL_BYTE_N, FL_READY_BUSY;
	logic [AV_AW-1:0] AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, v;
	logic [19:0] FL_ADDR;
	logic [15:0] FL_DQ_OUT, FL_DQ_IN;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	fcs_row_type rows [18];
	logic [31:0] bad [3];
	fcs_ctrl u_dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .FL_ADDR(FL_ADDR),
		.FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE), .FL_DQ_IN(FL_DQ_IN), .FL_CE_N(FL_CE_N),
		.FL_WE_N(FL_WE_N), .FL_OE_N(FL_OE_N), .FL_BYTE_N(FL_BYTE_N), .FL_READY_BUSY(FL_READY_BUSY));
	fcs_flash_model u_flash (.fl_addr(FL_ADDR), .fl_dq_out(FL_DQ_OUT), .fl_ce_n(FL_CE_N),
		.fl_we_n(FL_WE_N), .fl_oe_n(FL_OE_N), .fl_byte_n(FL_BYTE_N), .fl_dq_in(FL_DQ_IN),
		.fl_ready_busy(FL_READY_BUSY));
	initial begin
		CLOCK = 1'b0;
		forever #4 CLOCK = ~CLOCK;
	end
	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Ceiling well above the longest suspend plus erase run
	always @(posedge CLOCK) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic av_wr(input logic [AV_AW-1:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= 1'b1;
		do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
		AVS_WRITE <= 1'b0;
	endtask
	task automatic av_rd(input logic [AV_AW-1:0] a, output logic [31:0] d);
		@(posedge CLOCK);
		AVS_ADDRESS <= a;
		AVS_READ <= 1'b1;
		do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
		d = AVS_READDATA;
		AVS_READ <= 1'b0;
	endtask
	task automatic do_op(input logic [31:0] c, input logic [19:0] a, input logic [15:0] w);
		int n;
		av_wr(REG_ADDR, 32'(a));
		av_wr(REG_WDATA, 32'(w));
		av_wr(REG_CMD, c);
		n = 0;
		v = 32'h1;
		while (v[ST_BUSY_BIT] !== 1'b0 && n < 3000) begin
			av_rd(REG_STATUS, v);
			n++;
		end
		check(32'(v[ST_BUSY_BIT]), 32'h0);
	endtask
	task automatic do_reset();
		@(posedge CLOCK);
		RESET_N <= 1'b0;
		repeat (16) @(posedge CLOCK);
		check(32'({FL_CE_N, FL_WE_N, FL_OE_N, FL_DQ_OE, FL_BYTE_N, AVS_WAITREQUEST}), 32'h3b);
		check(32'(FL_ADDR), 32'h0);
		RESET_N <= 1'b1;
		av_rd(REG_STATUS, v);
		check(v & 32'hdf, 32'h0);
		av_rd(REG_RDATA, v);
		check(v, 32'h0);
		$display("Reset test done");
	endtask
	initial begin
		{RESET_N, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA} = '0;
		rows = '{'{32'(OP_PROGRAM), 20'h00100, 16'h1234, REG_STATUS, 32'h40, 32'h0},
			'{32'(OP_READ), 20'h00100, 16'h0, REG_RDATA, 32'hffff, 32'h1234},
			'{32'(OP_READ), 20'h00100, 16'h0, REG_STATUS, 32'h20, 32'h20},
			'{32'(OP_BYP_ENTER), 20'h0, 16'h0, REG_STATUS, 32'h2, 32'h2},
			'{32'(OP_BYP_PROG), 20'h00200, 16'h5a5a, REG_STATUS, 32'h2, 32'h2},
			'{32'(OP_READ), 20'h00200, 16'h0, REG_RDATA, 32'hffff, 32'h5a5a},
			'{32'(OP_BYP_RESET), 20'h0, 16'h0, REG_STATUS, 32'h2, 32'h0},
			'{32'(OP_AUTOSEL), 20'h0, 16'h0, REG_STATUS, 32'h10, 32'h10},
			'{32'(OP_PROT_VERIFY), 20'h01000, 16'h0, REG_RDATA, 32'hff, 32'h01},
			'{32'(OP_PROT_VERIFY), 20'h02000, 16'h0, REG_RDATA, 32'hff, 32'h00},
			'{32'(OP_RESET), 20'h0, 16'h0, REG_STATUS, 32'h10, 32'h0},
			'{32'h100 | 32'(OP_PROGRAM), 20'h00300, 16'h00c3, REG_STATUS, 32'h40, 32'h0},
			'{32'h100 | 32'(OP_READ), 20'h00300, 16'h0, REG_RDATA, 32'hff, 32'hc3},
			'{32'(OP_SECTOR_ERASE), 20'h03000, 16'h0, REG_STATUS, 32'h24, 32'h04},
			'{32'(OP_SUSPEND), 20'h0, 16'h0, REG_STATUS, 32'h8, 32'h8},
			'{32'(OP_READ), 20'h00100, 16'h0, REG_RDATA, 32'hffff, 32'h1234},
			'{32'(OP_RESUME), 20'h0, 16'h0, REG_STATUS, 32'h8, 32'h0},
			'{32'(OP_POLL), 20'h03000, 16'h0, REG_STATUS, 32'h4, 32'h0}};
		bad = '{32'(OP_RESUME), 32'(OP_BYP_PROG), 32'h0000000f};
		do_reset();
		foreach (rows[i]) begin
			do_op(rows[i].cmd, rows[i].addr, rows[i].wd);
			av_rd(rows[i].rg, v);
			check(v & rows[i].mask, rows[i].exp);
		end
		$display("Command table test done");
		foreach (bad[i]) begin
			do_op(bad[i], 20'h0, 16'h0);
			av_rd(REG_STATUS, v);
			check(v & 32'h80, 32'h80);
			av_wr(REG_STATUS, 32'h80);
			av_rd(REG_STATUS, v);
			check(v & 32'h80, 32'h0);
		end
		$display("Refusal test done");
		do_op(32'(OP_CHIP_ERASE), 20'h0, 16'h0);
		do_op(32'(OP_SUSPEND), 20'h0, 16'h0);
		av_rd(REG_STATUS, v);
		check(v & 32'h88, 32'h80);
		do_op(32'(OP_POLL), 20'h00100, 16'h0);
		do_op(32'(OP_READ), 20'h00100, 16'h0);
		av_rd(REG_RDATA, v);
		check(v & 32'hffff, 32'hffff);
		$display("Chip erase test done");
		av_wr(3'h5, 32'h1234);
		av_rd(3'h5, v);
		check(v, 32'h0);
		$display("Unmapped test done");
		do_reset();
		report_and_stop();
	end
endmodule
bind fcs_ctrl fcs_ctrl_assertions u_chk (.CLOCK(CLOCK), .RESET_N(RESET_N),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.FL_ADDR(FL_ADDR), .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE), .FL_DQ_IN(FL_DQ_IN),
	.FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N), .FL_OE_N(FL_OE_N), .FL_BYTE_N(FL_BYTE_N),
	.FL_READY_BUSY(FL_READY_BUSY));
`default_nettype wire
